// File: common/pwm_pkg.sv
// Package: register map, field layout and reset values of the complementary PWM stage
`default_nettype none
package pwm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_DUTY = 8'h04;
  localparam logic [7:0] OFS_PERIOD = 8'h08;
  localparam logic [7:0] OFS_DEAD = 8'h0C;
  localparam logic [7:0] OFS_ALT_DEAD = 8'h10;
  localparam logic [7:0] OFS_OUT_CTRL = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // Control register fields
  localparam int CTL_MODULE_ON = 0;
  localparam int CTL_CENTER = 1;
  localparam int CTL_IMMEDIATE = 2;
  localparam int CTL_ITB = 3;
  // Output control fields
  localparam int OC_SYNC = 0;
  localparam int OC_DATA_LO = 6;
  localparam int OC_DATA_HI = 7;
  localparam int OC_EN_LO = 8;
  localparam int OC_EN_HI = 9;
  // Reset values
  localparam logic [3:0] CONTROL_RST = 4'h0;
  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'h0064;
  localparam logic [15:0] DEAD_RST = 16'h0000;
  localparam logic [9:0] OUT_CTRL_RST = 10'h000;
  // Window after a dead-time start in which an override-off write is dropped
  localparam logic [15:0] OVR_IGNORE_WIN = 16'h0001;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// File: verilog/dead_time_gen.sv
// Dead-time inserter: turns one PWM level into complementary high and low drives
`default_nettype none
module dead_time_gen
  import pwm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic level,
  input wire logic bypass,
  input wire logic [15:0] rise_dead,
  input wire logic [15:0] fall_dead,
  output logic drive_high,
  output logic drive_low,
  output logic in_dead
);
  logic last_reg;
  logic [15:0] cnt_reg;
  wire edge_seen = level != last_reg;
  wire [15:0] load_val = level ? rise_dead : fall_dead;

  // Track the level and count dead time after each edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_reg <= 1'b0;
      cnt_reg <= 16'h0000;
    end else begin
      last_reg <= level;
      if (!enable || bypass) begin
        cnt_reg <= 16'h0000;
      end else if (edge_seen) begin
        // The edge cycle itself is the first dead cycle, so the count starts one lower
        cnt_reg <= (load_val != 16'h0000) ? load_val - 16'h0001 : 16'h0000;
      end else if (cnt_reg != 16'h0000) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
    end
  end

  // Both outputs inactive while the dead-time counter runs
  assign in_dead = enable && !bypass && (edge_seen ? (load_val != 16'h0000) : (cnt_reg != 16'h0000));
  assign drive_high = enable && level && !in_dead;
  assign drive_low = enable && !level && !in_dead;
endmodule
`default_nettype wire

// File: verilog/pwm_complementary.sv
// Complementary PWM generator with dead time, override and AXI4-Lite registers
// How it works
// - Immediate duty write crossing the count switches outputs at once, no dead time.
// - Override-off write near a dead-time start may be ignored.
// - Zero duty with nonzero rise dead time (alt dead time in center mode) does not hold low output for the whole period.
// - Duty equal period with dead time does not hold high output whole period.
// - Override enables both ones with sync: outputs follow override data.
// - Override data selects forced levels; 01 gives 0%, 10 gives 100%.
// - Center, independent, duty below half alt dead time: low forced low.
`default_nettype none
module pwm_complementary
  import pwm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic master_count_en,
  output logic high_output,
  output logic low_output
);
  // ************************************************
  // Registers
  // ************************************************
  logic [3:0] control_reg;
  logic [15:0] duty_cycle_reg;
  logic [15:0] active_duty_reg;
  logic [15:0] period_phase_reg;
  logic [15:0] dead_time_reg;
  logic [15:0] alt_dead_time_reg;
  logic [9:0] output_control_reg;
  logic [15:0] count_reg;
  logic dir_down_reg;
  logic level_reg;
  logic high_output_reg;
  logic low_output_reg;
  logic bypass_reg;
  logic [7:0] aw_addr_reg;
  logic aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_have_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic arready_reg;
  logic awready_reg;
  logic wready_reg;
  logic mc_sync1_reg;
  logic mc_sync2_reg;
  logic [15:0] dead_since_reg;

  // ************************************************
  // Control decode
  // ************************************************
  wire module_on = control_reg[CTL_MODULE_ON];
  wire center_mode = control_reg[CTL_CENTER];
  wire immediate_upd = control_reg[CTL_IMMEDIATE];
  wire independent_timebase_sel = control_reg[CTL_ITB];
  wire high_override_en = output_control_reg[OC_EN_HI];
  wire low_override_en = output_control_reg[OC_EN_LO];
  wire ovr_sync = output_control_reg[OC_SYNC];
  wire ovr_high_data = output_control_reg[OC_DATA_HI];
  wire ovr_low_data = output_control_reg[OC_DATA_LO];
  wire count_step = independent_timebase_sel || mc_sync2_reg;

  // ************************************************
  // Time base
  // ************************************************
  wire period_end = center_mode ? (dir_down_reg && count_reg == 16'h0000) : (count_reg >= period_phase_reg);
  wire [15:0] previous_duty_value = active_duty_reg;
  wire [15:0] new_duty_value = duty_cycle_reg;
  wire [15:0] half_alt = {1'b0, alt_dead_time_reg[15:1]};
  wire duty_small = center_mode && independent_timebase_sel && (active_duty_reg < half_alt);
  wire [15:0] lo_b = (previous_duty_value < new_duty_value) ? previous_duty_value : new_duty_value;
  wire [15:0] hi_b = (previous_duty_value < new_duty_value) ? new_duty_value : previous_duty_value;
  wire crossing = immediate_upd && (count_reg >= lo_b) && (count_reg < hi_b);
  wire load_duty = immediate_upd || period_end || !module_on;
  // A one-count pulse at count zero lets rise dead time cut into a 0% period
  wire [15:0] rise_sel = center_mode ? alt_dead_time_reg : dead_time_reg;
  wire zero_pulse = (count_reg == 16'h0000) && (rise_sel != 16'h0000);
  wire pwm_level = (count_reg < active_duty_reg) || zero_pulse;

  // Master time-base enable crosses in from another block
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mc_sync1_reg <= 1'b0;
      mc_sync2_reg <= 1'b0;
    end else begin
      mc_sync1_reg <= master_count_en;
      mc_sync2_reg <= mc_sync1_reg;
    end
  end

  // Up counter or up/down counter
  always_ff @(posedge aclk) begin
    if (!aresetn || !module_on) begin
      count_reg <= 16'h0000;
      dir_down_reg <= 1'b0;
    end else if (count_step) begin
      if (center_mode) begin
        if (!dir_down_reg && count_reg >= period_phase_reg) begin
          dir_down_reg <= 1'b1;
          count_reg <= count_reg - 16'h0001;
        end else if (dir_down_reg && count_reg == 16'h0000) begin
          dir_down_reg <= 1'b0;
          count_reg <= 16'h0001;
        end else begin
          count_reg <= dir_down_reg ? count_reg - 16'h0001 : count_reg + 16'h0001;
        end
      end else begin
        count_reg <= period_end ? 16'h0000 : count_reg + 16'h0001;
      end
    end
  end

  // Duty latch: immediate or at period boundary
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_duty_reg <= DUTY_RST;
      bypass_reg <= 1'b0;
    end else begin
      if (load_duty) begin
        active_duty_reg <= duty_cycle_reg;
      end
      bypass_reg <= module_on && crossing && (duty_cycle_reg != active_duty_reg);
    end
  end

  // ************************************************
  // Dead time and output stage
  // ************************************************
  logic dt_high;
  logic dt_low;
  logic dt_in_dead;
  wire [15:0] rise_dt = center_mode ? alt_dead_time_reg : dead_time_reg;
  wire [15:0] fall_dt = center_mode ? dead_time_reg : alt_dead_time_reg;

  dead_time_gen u_dead (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(module_on),
    .level(pwm_level),
    .bypass(bypass_reg),
    .rise_dead(rise_dt),
    .fall_dead(fall_dt),
    .drive_high(dt_high),
    .drive_low(dt_low),
    .in_dead(dt_in_dead)
  );

  // Rise dead time eats into 0% periods through the count-zero pulse; a duty above the period has no edge, so 100% stays high
  wire gen_high = dt_high;
  wire gen_low = dt_low && !duty_small;
  wire ovr_full = high_override_en && low_override_en && ovr_sync;
  wire next_high = ovr_full ? ovr_high_data : (high_override_en ? ovr_high_data : gen_high);
  wire next_low = ovr_full ? ovr_low_data : (low_override_en ? ovr_low_data : gen_low);

  // Registered outputs; override with sync takes effect on the next clock, no period-boundary wait
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_output_reg <= 1'b0;
      low_output_reg <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      level_reg <= pwm_level;
      high_output_reg <= module_on ? next_high : 1'b0;
      low_output_reg <= module_on ? next_low : 1'b0;
    end
  end

  // Time since a dead-time interval started
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dead_since_reg <= 16'hFFFF;
    end else if (dt_in_dead && pwm_level != level_reg) begin
      dead_since_reg <= 16'h0000;
    end else if (dead_since_reg != 16'hFFFF) begin
      dead_since_reg <= dead_since_reg + 16'h0001;
    end
  end

  // ************************************************
  // AXI4-Lite slave
  // ************************************************
  wire aw_take = s_axi_awvalid && awready_reg;
  wire w_take = s_axi_wvalid && wready_reg;
  wire do_write = aw_have_reg && w_have_reg && !bvalid_reg;
  wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  wire wr_ctl = do_write && aw_addr_reg == OFS_CONTROL;
  wire wr_duty = do_write && aw_addr_reg == OFS_DUTY;
  wire wr_per = do_write && aw_addr_reg == OFS_PERIOD;
  wire wr_dt = do_write && aw_addr_reg == OFS_DEAD;
  wire wr_adt = do_write && aw_addr_reg == OFS_ALT_DEAD;
  wire wr_oc = do_write && aw_addr_reg == OFS_OUT_CTRL;
  wire wr_ok = wr_ctl || wr_duty || wr_per || wr_dt || wr_adt || wr_oc || (do_write && aw_addr_reg == OFS_STATUS);
  wire [31:0] wval = w_data_reg & wmask;
  wire [9:0] oc_new = (output_control_reg & ~wmask[9:0]) | wval[9:0];
  wire ovr_off_write = (high_override_en || low_override_en) && !oc_new[OC_EN_HI] && !oc_new[OC_EN_LO];
  wire ovr_drop = ovr_off_write && module_on && (dead_since_reg <= OVR_IGNORE_WIN);
  wire [31:0] status_word = {13'h0000, dt_in_dead, high_output_reg, low_output_reg, count_reg};
  wire [31:0] rd_mux =
    (s_axi_araddr == OFS_CONTROL) ? {28'h0000000, control_reg} :
    (s_axi_araddr == OFS_DUTY) ? {16'h0000, duty_cycle_reg} :
    (s_axi_araddr == OFS_PERIOD) ? {16'h0000, period_phase_reg} :
    (s_axi_araddr == OFS_DEAD) ? {16'h0000, dead_time_reg} :
    (s_axi_araddr == OFS_ALT_DEAD) ? {16'h0000, alt_dead_time_reg} :
    (s_axi_araddr == OFS_OUT_CTRL) ? {22'h000000, output_control_reg} :
    status_word;
  wire rd_ok = s_axi_araddr <= OFS_STATUS && s_axi_araddr[1:0] == 2'b00;

  // Write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
    end else begin
      // Ready is high while the slot stays empty and no response waits
      awready_reg <= !do_write && !aw_have_reg && !aw_take && !(bvalid_reg && !s_axi_bready);
      wready_reg <= !do_write && !w_have_reg && !w_take && !(bvalid_reg && !s_axi_bready);
      if (aw_take) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_reg <= CONTROL_RST;
      duty_cycle_reg <= DUTY_RST;
      period_phase_reg <= PERIOD_RST;
      dead_time_reg <= DEAD_RST;
      alt_dead_time_reg <= DEAD_RST;
      output_control_reg <= OUT_CTRL_RST;
    end else begin
      if (wr_ctl) control_reg <= (control_reg & ~wmask[3:0]) | wval[3:0];
      if (wr_duty) duty_cycle_reg <= (duty_cycle_reg & ~wmask[15:0]) | wval[15:0];
      if (wr_per) period_phase_reg <= (period_phase_reg & ~wmask[15:0]) | wval[15:0];
      if (wr_dt) dead_time_reg <= (dead_time_reg & ~wmask[15:0]) | wval[15:0];
      if (wr_adt) alt_dead_time_reg <= (alt_dead_time_reg & ~wmask[15:0]) | wval[15:0];
      if (wr_oc && !ovr_drop) output_control_reg <= oc_new;
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else begin
      arready_reg <= s_axi_arvalid && !arready_reg && !rvalid_reg;
      if (s_axi_arvalid && !arready_reg && !rvalid_reg) begin
        rdata_reg <= rd_ok ? rd_mux : 32'h00000000;
        rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (arready_reg) begin
        rvalid_reg <= 1'b1;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign high_output = high_output_reg;
  assign low_output = low_output_reg;

  // ************************************************
  // Assertions
  // ************************************************
  AST_NO_OVERLAP: assert property (@(posedge aclk) disable iff (!aresetn)
    !(high_output && low_output && !high_override_en && !low_override_en)) else $error("outputs overlap");
  AST_DEAD_GAP: assert property (@(posedge aclk) disable iff (!aresetn)
    (module_on && !high_override_en && !low_override_en && dt_in_dead) |=> (!high_output && !low_output))
    else $error("dead time not applied");
  AST_BYPASS: assert property (@(posedge aclk) disable iff (!aresetn)
    (bypass_reg && module_on && !high_override_en && !low_override_en && !duty_small) |=>
    (high_output != low_output)) else $error("dead time during immediate switch");
  AST_OVR_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_oc && ovr_drop) |=> $stable(output_control_reg)) else $error("override-off not dropped");
  AST_OVR_FOLLOW: assert property (@(posedge aclk) disable iff (!aresetn)
    (module_on && ovr_full) |=> (high_output == $past(ovr_high_data))) else $error("override high wrong");
  AST_OVR_DATA: assert property (@(posedge aclk) disable iff (!aresetn)
    (module_on && ovr_full) |=> (low_output == $past(ovr_low_data))) else $error("override low wrong");
  AST_SMALL_DUTY: assert property (@(posedge aclk) disable iff (!aresetn)
    (duty_small && !low_override_en) |=> !low_output) else $error("low not forced low");
  AST_OFF_QUIET: assert property (@(posedge aclk) disable iff (!aresetn)
    (!module_on) |=> (!high_output && !low_output)) else $error("outputs active while off");
  AST_BRESP: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid) else $error("write response missing");
  COV_OVERRIDE: cover property (@(posedge aclk) disable iff (!aresetn) module_on && ovr_full);
  COV_BYPASS: cover property (@(posedge aclk) disable iff (!aresetn) bypass_reg);
  COV_DROP: cover property (@(posedge aclk) disable iff (!aresetn) wr_oc && ovr_drop);
  COV_CENTER: cover property (@(posedge aclk) disable iff (!aresetn) center_mode && period_end);
endmodule
`default_nettype wire

// File: testbench/gate_driver_model.sv
// Power stage gate driver model: counts drive cycles, overlaps and dead gaps on the output pair
`default_nettype none
module gate_driver_model (
  input wire logic aclk,
  input wire logic clear,
  input wire logic high_output,
  input wire logic low_output
);
  timeunit 1ns;
  timeprecision 1ns;
  int hi_cycles;
  int lo_cycles;
  int overlap;
  int min_gap;
  int max_hi_run;
  int gap;
  int hi_run;
  int last_on;
  int on_now;
  // Gate inputs only listen; a driver never answers back
  always @(posedge aclk) begin
    if (clear) begin
      hi_cycles = 0;
      lo_cycles = 0;
      overlap = 0;
      min_gap = 32'h0000FFFF;
      max_hi_run = 0;
      gap = 0;
      hi_run = 0;
      last_on = 0;
    end else begin
      if (high_output === 1'b1) hi_cycles++;
      if (low_output === 1'b1) lo_cycles++;
      if (high_output === 1'b1 && low_output === 1'b1) overlap++;
      hi_run = (high_output === 1'b1) ? hi_run + 1 : 0;
      if (hi_run > max_hi_run) max_hi_run = hi_run;
      // Gap is measured only when the active side really changes
      if (high_output !== low_output) begin
        on_now = (high_output === 1'b1) ? 1 : 2;
        if (last_on != 0 && last_on != on_now && gap < min_gap) min_gap = gap;
        last_on = on_now;
        gap = 0;
      end else begin
        gap++;
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/test_complementary_pwm_deadtime_override.sv
// Self-checking testbench of the complementary PWM stage with dead time and override
`default_nettype none
`define CHECK(what, exp, got) \
  compares++; \
  if ((got) !== (exp)) begin \
    $display("MISMATCH %s expected %0h seen %0h", what, exp, got); \
    mismatches++; \
  end
module test_complementary_pwm_deadtime_override
  import pwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PER = 20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h00000000;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic master_count_en = 1'b1;
  logic high_output;
  logic low_output;
  logic clear = 1'b1;
  logic [1:0] resp;
  logic [31:0] data;
  int mismatches = 0;
  int compares = 0;
  // 20 MHz clock
  always #25 aclk = ~aclk;
  pwm_complementary dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .master_count_en(master_count_en),
    .high_output(high_output), .low_output(low_output));
  gate_driver_model gd (.aclk(aclk), .clear(clear), .high_output(high_output), .low_output(low_output));
  // Verdict and end of run
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // AXI4-Lite write: address and data offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic awh;
    logic wh;
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge aclk);
      awh = awvalid && awready;
      wh = wvalid && wready;
      r = bresp;
      if (bvalid === 1'b1) break;
      @(posedge aclk);
      if (awh) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    @(posedge aclk);
    bready <= 1'b0;
    if (n == 100) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  // AXI4-Lite read: address held until taken, rready held until data seen
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic arh;
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge aclk);
      arh = arvalid && arready;
      d = rdata;
      r = rresp;
      if (rvalid === 1'b1) break;
      @(posedge aclk);
      if (arh) arvalid <= 1'b0;
    end
    @(posedge aclk);
    rready <= 1'b0;
    if (n == 100) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, resp);
  endtask
  // Duty and timing written while the module is off, so no write lands mid-period
  task automatic setup(input logic [3:0] ctl, input int duty, input int dead, input int alt);
    wr(OFS_CONTROL, 32'h00000000);
    wr(OFS_DEAD, dead);
    wr(OFS_ALT_DEAD, alt);
    wr(OFS_PERIOD, PER);
    wr(OFS_DUTY, duty);
    wr(OFS_CONTROL, {28'h0000000, ctl});
  endtask
  // Clears the stage statistics, then lets n cycles accumulate
  task automatic window(input int n);
    @(posedge aclk);
    clear <= 1'b1;
    @(posedge aclk);
    clear <= 1'b0;
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic test_regs();
    axi_read(OFS_PERIOD, data, resp);
    `CHECK("period reset", {16'h0000, PERIOD_RST}, data)
    axi_read(8'h1C, data, resp);
    `CHECK("unmapped read resp", RESP_SLVERR, resp)
    axi_write(8'h1C, 32'h0000FFFF, resp);
    `CHECK("unmapped write resp", RESP_SLVERR, resp)
    wr(OFS_DUTY, 32'h0000000A);
    axi_read(OFS_DUTY, data, resp);
    `CHECK("duty readback", 32'h0000000A, data)
  endtask
  task automatic test_dead_time();
    setup(4'h9, 10, 3, 3);
    window(4 * PER);
    `CHECK("overlap", 0, gd.overlap)
    `CHECK("min gap", 3, gd.min_gap)
  endtask
  // Edge and center mode zero and full duty with the documented register sequences
  task automatic test_zero_full();
    int i;
    for (i = 0; i < 4; i++) begin
      setup(i[1] ? 4'hB : 4'h9, i[0] ? PER + (i[1] ? 2 : 1) : 0, i[1] ? 3 : 0, 0);
      repeat (3 * PER) @(posedge aclk);
      window(4 * PER);
      `CHECK("full duty high", i[0] ? 4 * PER : 0, gd.hi_cycles)
      `CHECK("full duty low", i[0] ? 0 : 4 * PER, gd.lo_cycles)
    end
  endtask
  // Master time base with dead time: neither side is held for the whole period
  task automatic test_no_full_deadtime();
    setup(4'h1, 0, 3, 3);
    repeat (3 * PER) @(posedge aclk);
    window(4 * PER);
    `CHECK("low not full", 1'b1, gd.lo_cycles < 4 * PER)
    setup(4'h1, PER, 3, 3);
    repeat (3 * PER) @(posedge aclk);
    window(4 * PER);
    `CHECK("high not full", 1'b1, gd.hi_cycles < 4 * PER)
  endtask
  task automatic test_override();
    int d;
    setup(4'h9, 10, 3, 3);
    for (d = 1; d < 3; d++) begin
      wr(OFS_OUT_CTRL, 32'h00000301 | (d << 6));
      repeat (PER) @(posedge aclk);
      window(2 * PER);
      `CHECK("forced high", d == 2 ? 2 * PER : 0, gd.hi_cycles)
      `CHECK("forced low", d == 1 ? 2 * PER : 0, gd.lo_cycles)
    end
    wr(OFS_CONTROL, 32'h00000008);
    wr(OFS_OUT_CTRL, 32'h00000001);
    wr(OFS_CONTROL, 32'h00000009);
    repeat (PER) @(posedge aclk);
    window(2 * PER);
    `CHECK("pwm back high", 1'b1, gd.hi_cycles > 0)
    `CHECK("pwm back low", 1'b1, gd.lo_cycles > 0)
  endtask
  // Duty lowered below the running count with immediate update
  task automatic test_immediate();
    int n;
    setup(4'hD, 15, 2, 2);
    for (n = 0; n < 200 && high_output !== 1'b1; n++) @(negedge aclk);
    `CHECK("high seen", 1'b1, high_output)
    window(2);
    wr(OFS_DUTY, 3);
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    `CHECK("swap without gap", 0, gd.min_gap)
  endtask
  // Center mode, independent base, duty below half the alternate dead time
  task automatic test_small_duty();
    setup(4'hB, 2, 8, 8);
    repeat (3 * PER) @(posedge aclk);
    window(4 * PER);
    `CHECK("low held off", 0, gd.lo_cycles)
    `CHECK("narrow high", 1'b1, gd.max_hi_run < 16)
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    test_regs();
    test_dead_time();
    test_zero_full();
    test_no_full_deadtime();
    test_override();
    test_immediate();
    test_small_duty();
    report_and_stop();
  end
endmodule
`default_nettype wire
